/* File: logic/sxio_pkg.sv */
// Package for the sixteen-line I/O port: register map, fields and timing.
package sxio_pkg;

  localparam int unsigned LINES = 16;
  localparam logic [31:0] OFF_CTRL = 32'h080000d0;
  localparam logic [31:0] OFF_IN = 32'h080000d4;
  localparam logic [31:0] OFF_OUT = 32'h080000d8;
  localparam logic [31:0] OFF_OE = 32'h080000dc;
  localparam int unsigned MODE15_LSB = 30;
  localparam int unsigned MODES_LSB = 16;
  localparam int unsigned INV_LSB = 0;
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [15:0] RST_OUT = 16'h0000;
  localparam logic [15:0] RST_OE = 16'h0000;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LEVEL = 2'h1;
  localparam logic [1:0] MODE_EDGE = 2'h2;
  localparam logic [1:0] MODE_EDGE_BUSY = 2'h3;
  localparam int unsigned SYNC_STAGES = 3;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } sxio_wb_req_s;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } sxio_wb_rsp_s;

endpackage

/* File: logic/sxio_port.sv */
// Sixteen-line programmable I/O port with a classic Wishbone register slave.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module sxio_port (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire sxio_pkg::sxio_wb_req_s wb_req_i,
  output sxio_pkg::sxio_wb_rsp_s wb_rsp_o,
  input wire logic [15:0] general_io_lines_i,
  output logic [15:0] general_io_lines_o,
  output logic [15:0] general_io_lines_oe_o,
  input wire logic force_busy_clear_i,
  output logic force_port_busy_bit_o,
  output logic processor_interrupt_input_three_o
);

  logic [31:0] ctrl;
  logic [15:0] outreg;
  logic [15:0] oereg;
  logic [15:0] inreg;
  logic held;
  logic busy;
  logic ack;
  logic [31:0] rdat;
  logic [15:0] sync [sxio_pkg::SYNC_STAGES];
  logic [15:0] prev;
  logic irq;
  logic [15:0] pad;
  logic [15:0] oe_q;
  logic [31:0] next_ctrl;
  logic [15:0] next_outreg;
  logic [15:0] next_oereg;
  logic [15:0] next_inreg;
  logic next_held;
  logic next_busy;
  logic next_ack;
  logic [31:0] next_rdat;
  logic [15:0] next_prev;
  logic next_irq;
  logic [15:0] next_pad;
  logic [15:0] next_oe_q;
  logic [15:0] inv;
  logic [15:0] level;
  logic [15:0] rise;
  logic [15:0] rise_q;
  logic [15:0] next_rise_q;
  logic [31:0] merged_out;
  logic [31:0] merged_oe;
  logic [7:0] req;
  logic access;
  logic edge15;

  // Field extraction used for every upper line.
  function automatic logic [1:0] line_mode(input logic [31:0] c, input int unsigned n);
    line_mode = c[sxio_pkg::MODES_LSB + 2 * (n - 8) +: 2];
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    byte_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        byte_merge[8 * b +: 8] = nw[8 * b +: 8];
      end
    end
  endfunction

  // Three stages instead of two give extra settling time for slow edges.
  always_ff @(posedge core_clk_i) begin
    sync[0] <= general_io_lines_i;
    for (int s = 1; s < sxio_pkg::SYNC_STAGES; s++) begin
      sync[s] <= sync[s - 1];
    end
  end

  assign inv = ctrl[sxio_pkg::INV_LSB +: 16];
  assign level = sync[sxio_pkg::SYNC_STAGES - 1] ^ inv;
  assign rise = level & ~prev;
  assign access = wb_req_i.cyc & wb_req_i.stb & ~ack;
  // Edge requests take one more stage than level requests, so an edge is raised a cycle later.
  assign edge15 = rise_q[15] & (ctrl[sxio_pkg::MODE15_LSB +: 2] == sxio_pkg::MODE_EDGE_BUSY);
  assign merged_out = byte_merge({16'h0000, outreg}, wb_req_i.dat, wb_req_i.sel);
  assign merged_oe = byte_merge({16'h0000, oereg}, wb_req_i.dat, wb_req_i.sel);

  genvar g;
  generate
    for (g = 8; g < 16; g++) begin : g_req
      // Mode three is reserved below line fifteen and raises nothing there.
      assign req[g - 8] = (line_mode(ctrl, g) == sxio_pkg::MODE_LEVEL) ? level[g] :
                          ((line_mode(ctrl, g) == sxio_pkg::MODE_EDGE) ||
                           (g == 15 && line_mode(ctrl, g) == sxio_pkg::MODE_EDGE_BUSY)) ? rise_q[g] : 1'b0;
    end
  endgenerate

  always_comb begin
    next_ctrl = ctrl;
    next_outreg = outreg;
    next_oereg = oereg;
    next_inreg = level;
    next_held = held;
    next_busy = busy;
    next_ack = access;
    next_rdat = 32'h00000000;
    next_prev = level;
    next_rise_q = rise;
    next_irq = |req;
    next_oe_q = oereg;
    next_pad = outreg ^ inv;
    if (held) begin
      next_inreg = inreg;
    end
    if (access) begin
      next_held = 1'b0;
      if (wb_req_i.we) begin
        case (wb_req_i.adr)
          sxio_pkg::OFF_CTRL: next_ctrl = byte_merge(ctrl, wb_req_i.dat, wb_req_i.sel);
          sxio_pkg::OFF_OUT: next_outreg = merged_out[15:0];
          sxio_pkg::OFF_OE: next_oereg = merged_oe[15:0];
          default: next_ctrl = ctrl;
        endcase
      end else begin
        case (wb_req_i.adr)
          sxio_pkg::OFF_CTRL: next_rdat = ctrl;
          sxio_pkg::OFF_IN: next_rdat = {16'h0000, inreg};
          sxio_pkg::OFF_OUT: next_rdat = {16'h0000, outreg};
          sxio_pkg::OFF_OE: next_rdat = {16'h0000, oereg};
          default: next_rdat = 32'h00000000;
        endcase
      end
    end
    // Set wins over a same-cycle clear so a line fifteen edge is never lost.
    if (force_busy_clear_i) begin
      next_busy = 1'b0;
    end
    if (edge15) begin
      next_busy = 1'b1;
    end
    if (sys_rst_i) begin
      // Capture taken straight from the synchroniser in every reset cycle and
      // held until the first bus access, so drivers released with reset are not sampled.
      next_inreg = level;
      next_held = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    inreg <= next_inreg;
    held <= next_held;
    if (sys_rst_i) begin
      ctrl <= sxio_pkg::RST_CTRL;
      outreg <= sxio_pkg::RST_OUT;
      oereg <= sxio_pkg::RST_OE;
      busy <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h00000000;
      prev <= 16'h0000;
      rise_q <= 16'h0000;
      irq <= 1'b0;
      pad <= 16'h0000;
      oe_q <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      outreg <= next_outreg;
      oereg <= next_oereg;
      busy <= next_busy;
      ack <= next_ack;
      rdat <= next_rdat;
      prev <= next_prev;
      rise_q <= next_rise_q;
      irq <= next_irq;
      pad <= next_pad;
      oe_q <= next_oe_q;
    end
  end

  assign wb_rsp_o.ack = ack;
  assign wb_rsp_o.dat = rdat;
  assign general_io_lines_o = pad;
  assign general_io_lines_oe_o = oe_q;
  assign force_port_busy_bit_o = busy;
  assign processor_interrupt_input_three_o = irq;

endmodule

/* File: sim/sxio_port_props.sv */
// Assertion checker for the sixteen-line I/O port.
`timescale 1ns/1ps
module sxio_port_props (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire sxio_pkg::sxio_wb_req_s wb_req_i,
  input wire sxio_pkg::sxio_wb_rsp_s wb_rsp_o,
  input wire logic [15:0] general_io_lines_o,
  input wire logic [15:0] general_io_lines_oe_o,
  input wire logic force_busy_clear_i,
  input wire logic force_port_busy_bit_o,
  input wire logic processor_interrupt_input_three_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic ack, wr;
  assign ack = wb_rsp_o.ack;
  assign wr = ack && wb_req_i.we && wb_req_i.sel == 4'hf && wb_req_i.adr == sxio_pkg::OFF_OE;
  a_ack_pulse: assert property (ack |=> !ack) else $error("Ack too long.");
  a_ack_due: assert property (wb_req_i.stb && !ack |=> ack) else $error("Ack late.");
  a_dat_idle: assert property (!ack |-> wb_rsp_o.dat == 32'h0) else $error("Stray data.");
  a_oe_reset: assert property ($fell(sys_rst_i) |-> general_io_lines_oe_o == 16'h0)
    else $error("Enable not cleared.");
  a_oe_write: assert property (wr |=> general_io_lines_oe_o == $past(wb_req_i.dat[15:0]))
    else $error("Enable lost.");
  // Two idle cycles let a write accepted just before settle first.
  a_oe_hold: assert property ((!wb_req_i.cyc)[*2] |=> $stable(general_io_lines_oe_o))
    else $error("Enable moved.");
  a_out_hold: assert property ((!wb_req_i.cyc)[*2] |=> $stable(general_io_lines_o))
    else $error("Line moved.");
  a_busy_hold: assert property (force_port_busy_bit_o && !force_busy_clear_i |=> force_port_busy_bit_o)
    else $error("Busy lost.");
  c_write: cover property (wr);
  c_irq: cover property ($rose(processor_interrupt_input_three_o));
  c_busy: cover property ($rose(force_port_busy_bit_o));
endmodule
bind sxio_port sxio_port_props u_props (.*);

/* File: sim/sxio_lines.sv */
// External logic that drives the general lines whenever the port leaves them undriven.
`timescale 1ns/1ps
module sxio_lines (
  input wire logic [15:0] drv_i,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] pin_oe_i,
  output logic [15:0] level_o
);
  assign level_o = (pin_oe_i & pin_i) | (~pin_oe_i & drv_i);
endmodule

/* File: sim/sxio_port_tb.sv */
// Self-checking bench for the sixteen-line I/O port.
`timescale 1ns/1ps
module sxio_port_tb;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic force_busy_clear_i = 1'b0;
  logic force_port_busy_bit_o, processor_interrupt_input_three_o, seen;
  logic [15:0] ext = 16'ha5c3;
  logic [15:0] general_io_lines_i, general_io_lines_o, general_io_lines_oe_o;
  logic [31:0] r, d;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int ticks = 0;
  sxio_pkg::sxio_wb_req_s wb_req_i = '0;
  sxio_pkg::sxio_wb_rsp_s wb_rsp_o;
  sxio_port dut (.*);
  sxio_lines pins (.drv_i(ext), .pin_i(general_io_lines_o), .pin_oe_i(general_io_lines_oe_o), .level_o(general_io_lines_i));
  always #5 core_clk_i = ~core_clk_i;
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    wb_req_i <= '{a, v, 4'hf, w, 1'b1, 1'b1};
    if (!w) exp_q.push_back(v);
    do @(posedge core_clk_i); while (wb_rsp_o.ack !== 1'b1);
    wb_req_i <= '0;
  endtask
  task irq_try(input logic [31:0] c, input logic [15:0] a, input logic [15:0] b, input logic want);
    ext <= a;
    bus(1, sxio_pkg::OFF_CTRL, c);
    repeat (6) @(posedge core_clk_i);
    ext <= b;
    seen = 1'b0;
    repeat (8) begin
      @(posedge core_clk_i);
      seen = seen | processor_interrupt_input_three_o;
    end
    chk(seen, want);
  endtask
  always @(posedge core_clk_i) begin
    ticks++;
    if (ticks > 2000) begin
      miscompares++;
      results();
    end
    if (wb_rsp_o.ack === 1'b1 && wb_req_i.we === 1'b0) chk(wb_rsp_o.dat, exp_q.pop_front());
  end
  initial begin
    r = $urandom(53810);
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    ext <= 16'h1234;
    repeat (6) @(posedge core_clk_i);
    bus(0, sxio_pkg::OFF_IN, 32'ha5c3);
    bus(0, sxio_pkg::OFF_IN, 32'h1234);
    bus(0, sxio_pkg::OFF_OE, 32'h0);
    bus(0, 32'h080000e0, 32'h0);
    $display("reset capture done");
    r = $urandom;
    d = $urandom;
    ext <= r[31:16];
    bus(1, sxio_pkg::OFF_CTRL, {16'h0, r[15:0]});
    bus(0, sxio_pkg::OFF_IN, {16'h0, r[31:16] ^ r[15:0]});
    bus(1, sxio_pkg::OFF_OUT, d);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(general_io_lines_o, {16'h0, d[15:0] ^ r[15:0]});
    bus(1, sxio_pkg::OFF_OE, 32'hffff);
    bus(0, sxio_pkg::OFF_OUT, {16'h0, d[15:0]});
    bus(0, sxio_pkg::OFF_IN, {16'h0, d[15:0]});
    bus(1, sxio_pkg::OFF_OE, 32'h0);
    $display("drive done");
    for (int m = 0; m < 4; m++) begin
      ext <= 16'h0;
      bus(1, sxio_pkg::OFF_CTRL, {m[1:0], 30'h0});
      repeat (6) @(posedge core_clk_i);
      ext <= 16'h8000;
      seen = 1'b0;
      repeat (8) begin
        @(posedge core_clk_i);
        seen = seen | processor_interrupt_input_three_o;
      end
      chk(seen, m != 0);
      chk(force_port_busy_bit_o, m == 3);
      force_busy_clear_i <= 1'b1;
      @(posedge core_clk_i);
      force_busy_clear_i <= 1'b0;
    end
    irq_try(32'h80008000, 16'h8000, 16'h0000, 1'b1);
    chk(force_port_busy_bit_o, 1'b0);
    irq_try(32'h00010000, 16'h0000, 16'h0100, 1'b1);
    irq_try(32'h30000000, 16'h0000, 16'h4000, 1'b0);
    irq_try(32'h55550000, 16'h0000, 16'h00ff, 1'b0);
    $display("interrupt done");
    ext <= 16'hffff;
    bus(1, sxio_pkg::OFF_OUT, 32'h0);
    bus(1, sxio_pkg::OFF_OE, {16'h0, r[15:0]});
    repeat (4) @(posedge core_clk_i);
    bus(0, sxio_pkg::OFF_IN, {16'h0, ~r[15:0]});
    bus(1, sxio_pkg::OFF_OE, 32'h0);
    $display("open drain done");
    results();
  end
endmodule
